// File: bwsw_cfg.sv
// per-partition stride and window width configuration bank
`timescale 1ns/1ns
`include "bwsw_consts.svh"

// Function
// - enable bit 31 off: no stride regulation; on: regulate by stored stride
// - bits 15:0 hold stride minus one, an unsigned normalized cost
// - larger stride gives larger cost and smaller bandwidth share
// - only bw_alloc_width stride bits exist; width is reported
// - four separate stride instances, each reaching only its own space
// - with instance select, access uses selector instance and partition
// - without instance select, access uses partition identifier only
// - stride register at 0x0500, read-write; root and fourth only with realm feature
// - window not writable: register read-only, value from hardware
// - window writable: read-write, one width per partition
// - window integer us in 23:8, fraction in 7:0, 31:24 zero
// - window register at 0x0220; root and fourth need realm feature
// - without bandwidth partitioning window reads zero, ignores writes
// - four separate window instances, each reaching only its own space
// - selector low sixteen bits carry the partition identifier
// - selector bits 27:24 choose the resource instance
// - narrowing with flag not 1: error recorded, no write, read zero
module bwsw_cfg
  import bwsw_pkg::*;
#(
  parameter int NUM_PARTITION_IDENTIFIER = 4,
  parameter int NUM_RIS = 1,
  parameter bit HAS_INSTANCE_SELECT = 1'b0,
  parameter bit HAS_NARROWING = 1'b0,
  parameter bit HAS_REALM = 1'b1,
  parameter bit HAS_BW_PART = 1'b1,
  parameter bit WINDOW_WRITABLE = 1'b1,
  parameter int BW_ALLOC_WIDTH = 16
)
(
  input wire logic clk,
  input wire logic rst,
  input wire bwsw_req_s acc_req,
  input wire logic [3:0][31:0] part_sel,
  input wire logic [23:0] hw_window,
  input wire bwsw_query_s qry,
  output logic acc_done_r,
  output logic [31:0] acc_rdata_r,
  output logic range_err_r,
  output logic [4:0] bw_alloc_width_r,
  output logic reg_active_r,
  output logic [16:0] reg_cost_r,
  output logic [23:0] reg_window_r
);
  localparam int ENTRIES = 4 * NUM_RIS * NUM_PARTITION_IDENTIFIER;
  localparam logic [15:0] STRIDE_MASK =
    16'((32'h1 << BW_ALLOC_WIDTH) - 32'h1);
  localparam logic [4:0] ALLOC_WIDTH = 5'(BW_ALLOC_WIDTH);

  // refuse sizes that the storage and the masks cannot serve
  if (BW_ALLOC_WIDTH < 1 || BW_ALLOC_WIDTH > 16)
  begin : g_chk_width
    $error("bw alloc width must be 1 to 16");
  end
  if (NUM_PARTITION_IDENTIFIER < 1 || NUM_PARTITION_IDENTIFIER > 65536)
  begin : g_chk_partition_identifier
    $error("partition count out of range");
  end
  if (NUM_RIS < 1 || NUM_RIS > 16 || (!HAS_INSTANCE_SELECT && NUM_RIS != 1))
  begin : g_chk_ris
    $error("resource instance count out of range");
  end

  // ****************************************************************
  // selector decode
  // ****************************************************************
  function automatic int entry_index(input logic [1:0] sp,
                                     input logic [3:0] resource_instance_select,
                                     input logic [15:0] pid);
    entry_index = (int'(sp) * NUM_RIS + int'(resource_instance_select)) * NUM_PARTITION_IDENTIFIER
      + int'(pid);
  endfunction

  logic [31:0] sel;
  logic [15:0] sel_pid;
  logic [3:0] sel_ris;
  logic sel_internal;
  logic space_ok;
  logic flag_ok;
  logic in_range;
  logic hit_stride;
  logic hit_window;
  logic narrow_err;
  int acc_idx;

  always_comb
  begin
    sel = part_sel[acc_req.space];
    sel_pid = sel[`BWSW_SEL_PID_MSB:0];
    sel_ris = HAS_INSTANCE_SELECT ? sel[`BWSW_SEL_RIS_MSB:`BWSW_SEL_RIS_LSB]
                      : 4'h0;
    sel_internal = sel[`BWSW_SEL_INT_BIT];
    // narrowing: flag must be 1; otherwise flag is not checked
    flag_ok = !HAS_NARROWING || sel_internal;
    space_ok = HAS_REALM || acc_req.space == BWSW_SP_SECURE
      || acc_req.space == BWSW_SP_NONSECURE;
    in_range = int'(sel_pid) < NUM_PARTITION_IDENTIFIER && int'(sel_ris) < NUM_RIS;
    hit_stride = acc_req.addr == `BWSW_OFF_STRIDE;
    hit_window = HAS_BW_PART
      && acc_req.addr == `BWSW_OFF_WINDOW;
    narrow_err = acc_req.valid && space_ok && !flag_ok
      && (hit_stride || hit_window);
    acc_idx = entry_index(acc_req.space, sel_ris, sel_pid);
  end

  // ****************************************************************
  // configuration storage
  // ****************************************************************
  bwsw_entry_s store_r [ENTRIES];
  bwsw_entry_s store_nxt [ENTRIES];
  logic stride_we;
  logic window_we;

  always_comb
  begin
    stride_we = acc_req.valid && acc_req.write && hit_stride
      && space_ok && flag_ok && in_range;
    window_we = acc_req.valid && acc_req.write && hit_window
      && WINDOW_WRITABLE && space_ok && flag_ok
      && in_range;
  end

  generate
    for (genvar e = 0; e < ENTRIES; e++)
    begin : g_entry
      always_comb
      begin
        store_nxt[e] = store_r[e];
        if (stride_we && acc_idx == e)
        begin
          store_nxt[e].en = acc_req.wdata[`BWSW_EN_BIT];
          store_nxt[e].stride = acc_req.wdata[`BWSW_STRIDE_MSB:0]
            & STRIDE_MASK;
        end
        if (window_we && acc_idx == e)
          store_nxt[e].window =
            acc_req.wdata[`BWSW_WIN_MSB:0];
      end

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          store_r[e].en <= 1'b0;
          store_r[e].stride <= `BWSW_RST_STRIDE;
          store_r[e].window <= `BWSW_RST_WINDOW;
        end
        else
          store_r[e] <= store_nxt[e];
      end
    end
  endgenerate

  // ****************************************************************
  // frame read path and error report
  // ****************************************************************
  logic [31:0] rdata_nxt;
  logic done_nxt;
  logic err_nxt;
  bwsw_entry_s acc_ent;

  always_comb
  begin
    acc_ent = store_r[0];
    if (in_range)
      acc_ent = store_r[acc_idx];
    rdata_nxt = 32'h0000_0000;
    if (acc_req.valid && !acc_req.write && space_ok && flag_ok
        && in_range)
    begin
      if (hit_stride)
      begin
        rdata_nxt[`BWSW_EN_BIT] = acc_ent.en;
        rdata_nxt[`BWSW_STRIDE_MSB:0] = acc_ent.stride;
      end
      else if (hit_window)
        rdata_nxt[`BWSW_WIN_MSB:0] = WINDOW_WRITABLE ? acc_ent.window
          : hw_window;
    end
    done_nxt = acc_req.valid;
    err_nxt = HAS_NARROWING && narrow_err;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc_rdata_r <= 32'h0000_0000;
      acc_done_r <= 1'b0;
      range_err_r <= 1'b0;
      bw_alloc_width_r <= 5'h00;
    end
    else
    begin
      acc_rdata_r <= rdata_nxt;
      acc_done_r <= done_nxt;
      range_err_r <= err_nxt;
      bw_alloc_width_r <= ALLOC_WIDTH;
    end
  end

  // ****************************************************************
  // regulator lookup
  // ****************************************************************
  logic qry_ok;
  bwsw_entry_s qry_ent;
  logic active_nxt;
  logic [16:0] cost_nxt;
  logic [23:0] qwin_nxt;

  always_comb
  begin
    qry_ok = int'(qry.pid) < NUM_PARTITION_IDENTIFIER && int'(qry.resource_instance_select) < NUM_RIS;
    qry_ent = store_r[0];
    if (qry_ok)
      qry_ent = store_r[entry_index(qry.space, qry.resource_instance_select, qry.pid)];
    active_nxt = qry_ok && qry_ent.en;
    // cost is stride plus one, so larger value takes a smaller share
    cost_nxt = active_nxt ? 17'(qry_ent.stride) + 17'h0_0001
      : `BWSW_RST_COST;
    qwin_nxt = WINDOW_WRITABLE ? qry_ent.window : hw_window;
    if (!HAS_BW_PART)
      qwin_nxt = `BWSW_RST_WINDOW;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reg_active_r <= 1'b0;
      reg_cost_r <= `BWSW_RST_COST;
      reg_window_r <= `BWSW_RST_WINDOW;
    end
    else
    begin
      reg_active_r <= active_nxt;
      reg_cost_r <= cost_nxt;
      reg_window_r <= qwin_nxt;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rd_stride;
    acc_req.valid && !acc_req.write && hit_stride;
  endsequence

  sequence s_rd_window;
    acc_req.valid && !acc_req.write
      && acc_req.addr == `BWSW_OFF_WINDOW;
  endsequence

  AST_DONE_NEXT: assert property (acc_req.valid |=> acc_done_r
    ##1 (acc_done_r == $past(acc_req.valid)))
    else $error("access answer not one cycle later");
  AST_STRIDE_RSVD: assert property (s_rd_stride |=>
    acc_rdata_r[30:16] == 15'h0000)
    else $error("stride reserved bits not zero");
  AST_STRIDE_WIDTH: assert property (s_rd_stride |=>
    (acc_rdata_r[15:0] & ~STRIDE_MASK) == 16'h0000)
    else $error("unimplemented stride bits set");
  AST_WIN_RSVD: assert property (s_rd_window |=>
    acc_rdata_r[31:24] == 8'h00)
    else $error("window reserved bits not zero");
  AST_NO_BW_PART: assert property ((s_rd_window and !HAS_BW_PART)
    |=> acc_rdata_r == 32'h0000_0000)
    else $error("window read not zero without partitioning");
  AST_COST_IDLE: assert property (!reg_active_r |->
    reg_cost_r == `BWSW_RST_COST)
    else $error("cost charged while regulation is off");
  AST_COST_ORDER: assert property (active_nxt |=>
    reg_active_r && reg_cost_r == 17'($past(qry_ent.stride)) + 17'h0_0001)
    else $error("cost does not track stride");
  AST_NARROW_ERR: assert property (narrow_err && HAS_NARROWING
    |=> range_err_r && acc_rdata_r == 32'h0000_0000)
    else $error("internal id error not reported");
  AST_WIN_RO: assert property (acc_req.valid && acc_req.write
    && !WINDOW_WRITABLE |-> !window_we)
    else $error("read-only window written");
  AST_SPACE_ABSENT: assert property ((s_rd_stride and !space_ok)
    |=> acc_rdata_r == 32'h0000_0000)
    else $error("absent space instance returned data");

  // ****************************************************************
  // read-back and answer checks
  // ****************************************************************
  sequence s_rd_sel_ok;
    acc_req.valid && !acc_req.write && space_ok && flag_ok && in_range;
  endsequence

  // write, one idle cycle, then a read of the same entry
  sequence s_stride_rdback;
    stride_we ##1 !acc_req.valid
      ##1 (s_rd_stride and s_rd_sel_ok and acc_idx == $past(acc_idx, 2));
  endsequence

  sequence s_window_rdback;
    window_we ##1 !acc_req.valid
      ##1 (s_rd_window and s_rd_sel_ok and acc_idx == $past(acc_idx, 2));
  endsequence

  AST_STRIDE_RDBACK: assert property (s_stride_rdback |=>
    acc_rdata_r[`BWSW_EN_BIT] == $past(acc_req.wdata[`BWSW_EN_BIT], 3)
    && acc_rdata_r[`BWSW_STRIDE_MSB:0]
    == ($past(acc_req.wdata[`BWSW_STRIDE_MSB:0], 3) & STRIDE_MASK))
    else $error("stride read back differs from the write");
  AST_WIN_RDBACK: assert property (s_window_rdback |=>
    acc_rdata_r[`BWSW_WIN_MSB:0]
    == $past(acc_req.wdata[`BWSW_WIN_MSB:0], 3))
    else $error("window read back differs from the write");
  AST_STRIDE_STORE: assert property (stride_we |=>
    store_r[$past(acc_idx)].en == $past(acc_req.wdata[`BWSW_EN_BIT])
    && store_r[$past(acc_idx)].stride
    == ($past(acc_req.wdata[`BWSW_STRIDE_MSB:0]) & STRIDE_MASK))
    else $error("stride word not stored");
  AST_WIN_STORE: assert property (window_we |=>
    store_r[$past(acc_idx)].window == $past(acc_req.wdata[`BWSW_WIN_MSB:0]))
    else $error("window width not stored");
  AST_QUIET: assert property (!acc_req.valid |=> !acc_done_r
    && !range_err_r && acc_rdata_r == 32'h0000_0000)
    else $error("answer without a request");
  AST_WR_NODATA: assert property (acc_req.valid && acc_req.write
    |=> acc_rdata_r == 32'h0000_0000)
    else $error("write answered with read data");
  AST_ALLOC_WIDTH: assert property (!$past(rst) |->
    bw_alloc_width_r == ALLOC_WIDTH)
    else $error("reported stride width wrong");
  AST_QRY_RANGE: assert property (!qry_ok |=> !reg_active_r
    && reg_cost_r == `BWSW_RST_COST)
    else $error("absent partition regulated");
  AST_ERR_CAUSE: assert property (!narrow_err |=>
    !range_err_r)
    else $error("error flag without an internal id fault");
endmodule // bwsw_cfg

// File: bwsw_cfg_bench.sv
// self-checking bench of the bandwidth stride and window config bank
`timescale 1ns/1ns
`include "bwsw_consts.svh"

`define CHK(n, g, e) chk(n, 32'(e), 32'(g), (g) !== (e))

module bw_stride_window_cfg_bench
  import bwsw_pkg::*;
;
  logic clk;
  logic rst;
  bwsw_req_s acc_req;
  logic [3:0][31:0] part_sel;
  logic [23:0] hw_window;
  bwsw_query_s qry;
  logic acc_done_r;
  logic [31:0] acc_rdata_r;
  logic range_err_r;
  logic [4:0] bw_alloc_width_r;
  logic reg_active_r;
  logic [16:0] reg_cost_r;
  logic [23:0] reg_window_r;
  logic [31:0] rd;
  int bad_count;
  int check_count;
  int cycles;

  bwsw_cfg bwsw_cfg_i (
    .clk(clk), .rst(rst), .acc_req(acc_req), .part_sel(part_sel),
    .hw_window(hw_window), .qry(qry), .acc_done_r(acc_done_r),
    .acc_rdata_r(acc_rdata_r), .range_err_r(range_err_r),
    .bw_alloc_width_r(bw_alloc_width_r), .reg_active_r(reg_active_r),
    .reg_cost_r(reg_cost_r), .reg_window_r(reg_window_r)
  );

  always #5 clk = ~clk;

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g, input logic miss);
    check_count++;
    if (miss)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // one frame access with an idle cycle before it
  task automatic bus(input bwsw_space_e sp, input logic wr,
                     input logic [15:0] ad, input logic [31:0] wd);
    @(posedge clk);
    #1;
    acc_req = '{valid: 1'b1, write: wr, space: sp, addr: ad, wdata: wd};
    @(posedge clk);
    #1;
    acc_req.valid = 1'b0;
    `CHK("done", acc_done_r, 1'b1); // one cycle answer
    `CHK("error", range_err_r, 1'b0); // no error flag
    rd = acc_rdata_r;
  endtask

  task automatic look(input bwsw_space_e sp, input logic [15:0] pid);
    @(posedge clk);
    #1;
    qry = '{space: sp, resource_instance_select: 4'h0, pid: pid};
    @(posedge clk);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    part_sel[0] = 32'h0000_0003;
    bus(BWSW_SP_SECURE, 1'b0, `BWSW_OFF_STRIDE, 32'h0000_0000);
    `CHK("alloc width", bw_alloc_width_r, 5'h10); // width shown
    `CHK("stride reset", rd, 32'h0000_0000); // off after reset
    $display("test reset done");
  endtask

  task automatic t_stride();
    part_sel[1] = 32'h0000_0001;
    bus(BWSW_SP_NONSECURE, 1'b1, `BWSW_OFF_STRIDE, 32'hFFFF_FFFF);
    `CHK("write rdata", rd, 32'h0000_0000); // zero on store
    bus(BWSW_SP_NONSECURE, 1'b0, `BWSW_OFF_STRIDE, 32'h0000_0000);
    `CHK("stride", rd, 32'h8000_FFFF); // reserved read 0
    look(BWSW_SP_NONSECURE, 16'h0001);
    `CHK("active", reg_active_r, 1'b1); // enabled
    `CHK("cost max", reg_cost_r, 17'h1_0000); // largest cost
    bus(BWSW_SP_NONSECURE, 1'b1, `BWSW_OFF_STRIDE, 32'h0000_0002);
    look(BWSW_SP_NONSECURE, 16'h0001);
    `CHK("inactive", reg_active_r, 1'b0); // disabled
    `CHK("cost off", reg_cost_r, 17'h0_0000); // no charge
    bus(BWSW_SP_NONSECURE, 1'b1, `BWSW_OFF_STRIDE, 32'h8000_0002);
    look(BWSW_SP_NONSECURE, 16'h0001);
    `CHK("cost small", reg_cost_r, 17'h0_0003); // stride plus one
    $display("test stride done");
  endtask

  task automatic t_spaces();
    for (int s = 0; s < 4; s++)
    begin
      part_sel[s] = 32'h0000_0002;
      bus(bwsw_space_e'(s), 1'b1, `BWSW_OFF_STRIDE, 32'h8000_0010 + 32'(s));
      bus(bwsw_space_e'(s), 1'b1, `BWSW_OFF_WINDOW, 32'h0012_3400 + 32'(s));
    end
    for (int s = 0; s < 4; s++)
    begin
      bus(bwsw_space_e'(s), 1'b0, `BWSW_OFF_STRIDE, 32'h0000_0000);
      `CHK("space stride", rd, 32'h8000_0010 + 32'(s)); // own space
      bus(bwsw_space_e'(s), 1'b0, `BWSW_OFF_WINDOW, 32'h0000_0000);
      `CHK("space win", rd, 32'h0012_3400 + 32'(s)); // own space
    end
    $display("test spaces done");
  endtask

  task automatic t_window();
    part_sel[0] = 32'h0000_0003;
    bus(BWSW_SP_SECURE, 1'b1, `BWSW_OFF_WINDOW, 32'hFFFF_FFFF);
    bus(BWSW_SP_SECURE, 1'b0, `BWSW_OFF_WINDOW, 32'h0000_0000);
    `CHK("window", rd, 32'h00FF_FFFF); // top byte reads 0
    look(BWSW_SP_SECURE, 16'h0003);
    `CHK("reg window", reg_window_r, 24'hFF_FFFF); // stored width
    look(BWSW_SP_SECURE, 16'h0000);
    `CHK("other window", reg_window_r, 24'h00_0000); // per pid
    $display("test window done");
  endtask

  task automatic t_partition_identifier();
    part_sel[0] = 32'h0000_0000;
    bus(BWSW_SP_SECURE, 1'b1, `BWSW_OFF_STRIDE, 32'h8000_0005);
    part_sel[0] = 32'h0000_0001;
    bus(BWSW_SP_SECURE, 1'b1, `BWSW_OFF_STRIDE, 32'h0000_0007);
    part_sel[0] = 32'h0000_0000;
    bus(BWSW_SP_SECURE, 1'b0, `BWSW_OFF_STRIDE, 32'h0000_0000);
    `CHK("pid0", rd, 32'h8000_0005); // selected by pid
    look(BWSW_SP_SECURE, 16'h0000);
    `CHK("pid0 cost", reg_cost_r, 17'h0_0006); // separate entry
    part_sel[0] = 32'h0000_0004;
    bus(BWSW_SP_SECURE, 1'b1, `BWSW_OFF_STRIDE, 32'h8000_0009);
    bus(BWSW_SP_SECURE, 1'b0, `BWSW_OFF_STRIDE, 32'h0000_0000);
    `CHK("pid range", rd, 32'h0000_0000); // missing pid reads 0
    look(BWSW_SP_SECURE, 16'h0004);
    `CHK("absent active", reg_active_r, 1'b0); // no entry
    `CHK("absent cost", reg_cost_r, 17'h0_0000); // no charge
    bus(BWSW_SP_SECURE, 1'b1, 16'h0504, 32'hFFFF_FFFF);
    bus(BWSW_SP_SECURE, 1'b0, 16'h0504, 32'h0000_0000);
    `CHK("unmapped", rd, 32'h0000_0000); // hole reads 0
    $display("test partition_identifier done");
  endtask

  // ****************************************
  // main sequence and hang guard
  // ****************************************
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      complete_run();
    end
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    acc_req = '0;
    part_sel = '0; // internal flag kept 0, no narrowing
    hw_window = 24'hA5_5A3C;
    qry = '0;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_stride();
    t_spaces();
    t_window();
    t_partition_identifier();
    complete_run();
  end
endmodule // bw_stride_window_cfg_bench

// File: bwsw_consts.svh
// offsets, field positions and reset values of the bandwidth config bank
`ifndef BWSW_CONSTS_SVH
`define BWSW_CONSTS_SVH
`define BWSW_OFF_WINDOW 16'h0220
`define BWSW_OFF_STRIDE 16'h0500
`define BWSW_EN_BIT 31
`define BWSW_STRIDE_MSB 15
`define BWSW_WIN_MSB 23
`define BWSW_SEL_PID_MSB 15
`define BWSW_SEL_INT_BIT 16
`define BWSW_SEL_RIS_MSB 27
`define BWSW_SEL_RIS_LSB 24
`define BWSW_RST_STRIDE 16'h0000
`define BWSW_RST_WINDOW 24'h00_0000
`define BWSW_RST_COST 17'h0_0000
`endif

// File: bwsw_pkg.sv
// types of the bandwidth stride and window configuration bank
package bwsw_pkg;
  typedef enum logic [1:0] {
    BWSW_SP_SECURE = 2'h0,
    BWSW_SP_NONSECURE = 2'h1,
    BWSW_SP_ROOT = 2'h2,
    BWSW_SP_FOURTH = 2'h3
  } bwsw_space_e;

  // one frame access: taken in the cycle valid is high
  typedef struct packed {
    logic valid;
    logic write;
    bwsw_space_e space;
    logic [15:0] addr;
    logic [31:0] wdata;
  } bwsw_req_s;

  // regulator lookup of one partition's settings
  typedef struct packed {
    bwsw_space_e space;
    logic [3:0] resource_instance_select;
    logic [15:0] pid;
  } bwsw_query_s;

  typedef struct packed {
    logic en;
    logic [15:0] stride;
    logic [23:0] window;
  } bwsw_entry_s;
endpackage
